// *** shared/dscg_pkg.sv ***
// deep-sleep clock gate block: register map, field layout and modes.
// assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
package dscg_pkg;

  // register window
  localparam logic [31:0] BASE_ADDR = 32'h400FE000;
  localparam logic [19:0] BASE_PAGE = 20'h400FE;
  localparam logic [11:0] CFG_OFS = 12'h060;
  localparam logic [11:0] RUN_OFS = 12'h100;
  localparam logic [11:0] SLEEP_OFS = 12'h110;
  localparam logic [11:0] DEEP_OFS = 12'h128;
  localparam logic [11:0] STAT_OFS = 12'h200;
  localparam logic [11:0] MASK_OFS = 12'h204;

  // gate word layout, shared by the three gate words, status and mask
  localparam int PHY_BIT = 30;
  localparam int MAC_BIT = 28;
  localparam int PORT_W = 7;
  localparam int NUNIT = 9;
  localparam int UNIT_PHY = 8;
  localparam int UNIT_MAC = 7;
  localparam logic [31:0] GATE_MASK = 32'h5000007F;
  localparam logic [31:0] GATE_RST = 32'h00000000;

  // run-mode clock configuration word
  localparam int ACG_BIT = 27;
  localparam logic [31:0] CFG_MASK = 32'h08000000;
  localparam logic [31:0] CFG_RST = 32'h00000000;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DSCG_RUN = 2'h0,
    DSCG_SLEEP = 2'h1,
    DSCG_DEEP = 2'h3
  } dscg_mode_t;

  function automatic logic [NUNIT-1:0] dscg_to_unit(logic [31:0] w);
    return {w[PHY_BIT], w[MAC_BIT], w[PORT_W-1:0]};
  endfunction : dscg_to_unit

  function automatic logic [31:0] dscg_to_word(logic [NUNIT-1:0] u);
    logic [31:0] r;
    r = GATE_RST;
    r[PHY_BIT] = u[UNIT_PHY];
    r[MAC_BIT] = u[UNIT_MAC];
    r[PORT_W-1:0] = u[PORT_W-1:0];
    return r;
  endfunction : dscg_to_word

endpackage : dscg_pkg

// *** shared/dscg_gate_if.sv ***
// gate selection signals between the register block and the selector.
// assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface dscg_gate_if;
  logic [dscg_pkg::NUNIT-1:0] run_en;
  logic [dscg_pkg::NUNIT-1:0] sleep_en;
  logic [dscg_pkg::NUNIT-1:0] deep_en;
  logic [dscg_pkg::NUNIT-1:0] cur_en;
  logic [dscg_pkg::NUNIT-1:0] access;
  logic [dscg_pkg::NUNIT-1:0] nxt_en;
  logic [dscg_pkg::NUNIT-1:0] fault;
  logic auto_clock_gating;
  dscg_pkg::dscg_mode_t mode;

  modport ctrl (
    output run_en, sleep_en, deep_en, cur_en, access, auto_clock_gating, mode,
    input nxt_en, fault
  );
  modport sel (
    input run_en, sleep_en, deep_en, cur_en, access, auto_clock_gating, mode,
    output nxt_en, fault
  );
endinterface : dscg_gate_if

// *** core/dscg_gate_sel.sv ***
// picks the gate word that applies in the current power mode and flags
// accesses to units whose clock is stopped.
// assumes cur_en is the enable the units see now; purely combinational.
`timescale 1ns/1ps
module dscg_gate_sel (
  // selection signals
  dscg_gate_if.sel gi
);
  wire use_sleep;
  wire use_deep;

  // sleep and deep words only count with automatic gating on
  assign use_sleep = gi.auto_clock_gating && (gi.mode == dscg_pkg::DSCG_SLEEP);
  assign use_deep = gi.auto_clock_gating && (gi.mode == dscg_pkg::DSCG_DEEP);
  assign gi.nxt_en = use_deep ? gi.deep_en :
                     (use_sleep ? gi.sleep_en : gi.run_en);
  assign gi.fault = gi.access & ~gi.cur_en;
endmodule : dscg_gate_sel

// *** core/dscg_top.sv ***
// file holds the deep-sleep clock gate register block with its AXI4-Lite
// slave, mode synchroniser, fault detection and interrupt.
// assumes power-mode requests come asynchronously from pins and unit access
// strobes come from the bus fabric on aclk.
`timescale 1ns/1ps
module dscg_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // power mode requests, asynchronous
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  // unit side
  input wire logic [8:0] unit_access,
  output logic [8:0] unit_clk_en,
  output logic bus_fault,
  // interrupt
  output logic irq
);

  // register state
  logic [31:0] cfg_ff;
  logic [31:0] run_ff;
  logic [31:0] sleep_ff;
  logic [31:0] deep_ff;
  logic [31:0] stat_ff;
  logic [31:0] mask_ff;
  logic [8:0] clk_en_ff;
  logic bus_fault_ff;
  logic irq_ff;

  // bus state
  logic awready_ff;
  logic wready_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [11:0] waddr_ff;
  logic wpage_ok_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // mode synchroniser, first stage read only by the second
  logic [1:0] msync1_ff;
  logic [1:0] msync2_ff;

  dscg_gate_if gi ();

  dscg_gate_sel u_sel (
    .gi(gi)
  );

  // power mode from the synchronised pins
  wire sync_sleep;
  wire sync_deep;
  dscg_pkg::dscg_mode_t cur_mode;

  assign sync_sleep = msync2_ff[0];
  assign sync_deep = msync2_ff[1];
  assign cur_mode = sync_deep ? dscg_pkg::DSCG_DEEP :
                    (sync_sleep ? dscg_pkg::DSCG_SLEEP : dscg_pkg::DSCG_RUN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msync1_ff <= 2'h0;
      msync2_ff <= 2'h0;
    end else begin
      msync1_ff <= {deep_sleep_req, sleep_req};
      msync2_ff <= msync1_ff;
    end
  end

  // selector hookup
  wire acg_on;

  assign acg_on = cfg_ff[dscg_pkg::ACG_BIT];
  assign gi.run_en = dscg_pkg::dscg_to_unit(run_ff);
  assign gi.sleep_en = dscg_pkg::dscg_to_unit(sleep_ff);
  assign gi.deep_en = dscg_pkg::dscg_to_unit(deep_ff);
  assign gi.cur_en = clk_en_ff;
  assign gi.access = unit_access;
  assign gi.auto_clock_gating = acg_on;
  assign gi.mode = cur_mode;

  // write channel
  wire aw_take;
  wire w_take;
  wire do_write;
  wire nxt_aw_held;
  wire nxt_w_held;
  wire nxt_bvalid;
  wire [31:0] bmask;
  wire wmapped;
  wire wr_cfg;
  wire wr_run;
  wire wr_sleep;
  wire wr_deep;
  wire wr_stat;
  wire wr_mask;

  assign aw_take = awvalid && awready_ff;
  assign w_take = wvalid && wready_ff;
  // write once both halves are held and the previous answer has gone
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign nxt_aw_held = aw_take || (aw_held_ff && !do_write);
  assign nxt_w_held = w_take || (w_held_ff && !do_write);
  assign nxt_bvalid = do_write || (bvalid_ff && !bready);
  assign bmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                  {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign wr_cfg = do_write && wpage_ok_ff && (waddr_ff == dscg_pkg::CFG_OFS);
  assign wr_run = do_write && wpage_ok_ff && (waddr_ff == dscg_pkg::RUN_OFS);
  assign wr_sleep = do_write && wpage_ok_ff &&
                    (waddr_ff == dscg_pkg::SLEEP_OFS);
  assign wr_deep = do_write && wpage_ok_ff && (waddr_ff == dscg_pkg::DEEP_OFS);
  assign wr_stat = do_write && wpage_ok_ff && (waddr_ff == dscg_pkg::STAT_OFS);
  assign wr_mask = do_write && wpage_ok_ff && (waddr_ff == dscg_pkg::MASK_OFS);
  assign wmapped = wr_cfg || wr_run || wr_sleep || wr_deep ||
                   wr_stat || wr_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= dscg_pkg::RESP_OKAY;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      awready_ff <= !nxt_aw_held;
      wready_ff <= !nxt_w_held;
      bvalid_ff <= nxt_bvalid;
      if (do_write) begin
        bresp_ff <= wmapped ? dscg_pkg::RESP_OKAY : dscg_pkg::RESP_SLVERR;
      end
    end
  end

  // payload latches carry no control meaning, no reset needed
  always_ff @(posedge aclk) begin
    if (aw_take) begin
      waddr_ff <= awaddr[11:0];
      wpage_ok_ff <= (awaddr[31:12] == dscg_pkg::BASE_PAGE);
    end
    if (w_take) begin
      wdata_ff <= wdata;
      wstrb_ff <= wstrb;
    end
  end

  // register update
  wire [31:0] merged;
  wire [31:0] stat_set;
  wire [31:0] stat_clr;
  wire [31:0] nxt_stat;

  assign merged = wdata_ff & bmask;
  assign stat_set = dscg_pkg::dscg_to_word(gi.fault);
  assign stat_clr = wr_stat ? (merged & dscg_pkg::GATE_MASK) : 32'h00000000;
  // a fault in the clearing cycle stays recorded
  assign nxt_stat = (stat_ff & ~stat_clr) | stat_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff <= dscg_pkg::CFG_RST;
      run_ff <= dscg_pkg::GATE_RST;
      sleep_ff <= dscg_pkg::GATE_RST;
      deep_ff <= dscg_pkg::GATE_RST;
      stat_ff <= dscg_pkg::GATE_RST;
      mask_ff <= dscg_pkg::GATE_RST;
    end else begin
      if (wr_cfg) begin
        cfg_ff <= ((cfg_ff & ~bmask) | merged) & dscg_pkg::CFG_MASK;
      end
      if (wr_run) begin
        run_ff <= ((run_ff & ~bmask) | merged) & dscg_pkg::GATE_MASK;
      end
      if (wr_sleep) begin
        sleep_ff <= ((sleep_ff & ~bmask) | merged) & dscg_pkg::GATE_MASK;
      end
      if (wr_deep) begin
        deep_ff <= ((deep_ff & ~bmask) | merged) & dscg_pkg::GATE_MASK;
      end
      if (wr_mask) begin
        mask_ff <= ((mask_ff & ~bmask) | merged) & dscg_pkg::GATE_MASK;
      end
      stat_ff <= nxt_stat;
    end
  end

  // clock enables, fault, interrupt
  // enables are registered so each unit sees a glitch-free level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_en_ff <= 9'h000;
      bus_fault_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      clk_en_ff <= gi.nxt_en;
      bus_fault_ff <= |gi.fault;
      irq_ff <= |(nxt_stat & mask_ff);
    end
  end

  // read channel
  wire ar_take;
  wire nxt_rvalid;
  wire rpage_ok;
  wire [11:0] roff;
  logic [31:0] rd_word;
  logic rd_hit;

  assign ar_take = arvalid && arready_ff;
  assign nxt_rvalid = ar_take || (rvalid_ff && !rready);
  assign rpage_ok = (araddr[31:12] == dscg_pkg::BASE_PAGE);
  assign roff = araddr[11:0];

  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = rpage_ok;
    unique case (roff)
      dscg_pkg::CFG_OFS: rd_word = cfg_ff;
      dscg_pkg::RUN_OFS: rd_word = run_ff;
      dscg_pkg::SLEEP_OFS: rd_word = sleep_ff;
      dscg_pkg::DEEP_OFS: rd_word = deep_ff;
      dscg_pkg::STAT_OFS: rd_word = stat_ff;
      dscg_pkg::MASK_OFS: rd_word = mask_ff;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= dscg_pkg::RESP_OKAY;
    end else begin
      arready_ff <= !nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= rd_hit ? rd_word : 32'h00000000;
        rresp_ff <= rd_hit ? dscg_pkg::RESP_OKAY : dscg_pkg::RESP_SLVERR;
      end
    end
  end

  // outputs, all straight from flops
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign unit_clk_en = clk_en_ff;
  assign bus_fault = bus_fault_ff;
  assign irq = irq_ff;

  // assertions, all on aclk
  default clocking dscg_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  wire deep_auto;
  assign deep_auto = acg_on && (cur_mode == dscg_pkg::DSCG_DEEP);

  sequence deep_all_ones_wr_s;
    wr_deep && (wstrb_ff == 4'hF) && (wdata_ff == 32'hFFFFFFFF);
  endsequence
  sequence deep_read_s;
    ar_take && (araddr == {dscg_pkg::BASE_PAGE, dscg_pkg::DEEP_OFS});
  endsequence

  reset_clear_a:
  assert property (!$past(aresetn) |-> (deep_ff == dscg_pkg::GATE_RST) &&
                   (unit_clk_en == 9'h000))
  else $error("gate state not cleared after reset");
  deep_follow_a:
  assert property (deep_auto |=> unit_clk_en == $past(gi.deep_en))
  else $error("deep-sleep enables not applied");
  deep_off_a:
  assert property ((deep_auto && (deep_ff == dscg_pkg::GATE_RST))[*2]
                   |-> unit_clk_en == 9'h000)
  else $error("clock reaches a unit that is gated off");
  run_follow_a:
  assert property (!acg_on |=> unit_clk_en == $past(gi.run_en))
  else $error("run enables not applied without auto gating");
  sleep_follow_a:
  assert property (acg_on && (cur_mode == dscg_pkg::DSCG_SLEEP)
                   |=> unit_clk_en == $past(gi.sleep_en))
  else $error("sleep enables not applied");
  fault_gated_a:
  assert property (|(unit_access & ~unit_clk_en)
                   |=> bus_fault && (stat_ff != 32'h00000000))
  else $error("access to stopped unit not faulted");
  fault_none_a:
  assert property ((unit_access & ~unit_clk_en) == 9'h000 |=> !bus_fault)
  else $error("fault raised for a clocked unit");
  deep_bits_a:
  assert property (deep_all_ones_wr_s |=> deep_ff == dscg_pkg::GATE_MASK)
  else $error("deep word writable bits wrong");
  deep_reserved_a:
  assert property (rvalid && !$past(rvalid) && rresp == dscg_pkg::RESP_OKAY
                   |-> (rdata & ~dscg_pkg::GATE_MASK) == 32'h00000000 ||
                   $past(roff) != dscg_pkg::DEEP_OFS)
  else $error("reserved deep bits read nonzero");
  deep_decode_a:
  assert property (deep_read_s |=> rvalid && (rresp == dscg_pkg::RESP_OKAY) &&
                   (rdata == $past(deep_ff)) ##1 ($past(rready) ||
                   (rvalid && $stable(rdata))))
  else $error("deep word not decoded at its address");
  wr_answer_a:
  assert property (aw_held_ff && w_held_ff && !bvalid_ff |=> bvalid)
  else $error("write not answered");
  irq_level_a:
  assert property (|(stat_ff & mask_ff) ##1 (stat_ff == $past(stat_ff))
                   |-> irq)
  else $error("interrupt low with unmasked status set");

endmodule : dscg_top

// *** tb/dscg_top_test.sv ***
// self-checking bench for the deep-sleep clock gate register block.
// assumes dscg_top on one 50 MHz clock; the bench is the only bus master.
`timescale 1ns/1ps
module dscg_top_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, bus_fault, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic sleep_req = 1'b0, deep_sleep_req = 1'b0;
  logic [8:0] unit_access = 9'h000;
  logic [8:0] unit_clk_en;
  int err_total = 0;
  int num_checks = 0;
  logic [1:0] rsp;
  logic [31:0] rd;

  always #10 aclk = ~aclk;

  dscg_top u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
    .unit_access(unit_access), .unit_clk_en(unit_clk_en),
    .bus_fault(bus_fault), .irq(irq)
  );

  function automatic logic [31:0] adr(input logic [11:0] ofs);
    return {dscg_pkg::BASE_PAGE, ofs};
  endfunction : adr

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_unit(input logic [8:0] exp);
    num_checks++;
    if (unit_clk_en !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, unit_clk_en, exp);
    end
  endtask : chk_unit

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit

  // address and data offered together, each dropped at its own handshake
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    r = 2'h1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (bvalid === 1'b1 && !awvalid && !wvalid) begin
        r = bresp;
        done = 1'b1;
        bready <= 1'b0;
      end
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end
    chk_bit(done, 1'b1);
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    d = 32'h0;
    r = 2'h1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (!arvalid && rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        done = 1'b1;
        rready <= 1'b0;
      end
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end
    chk_bit(done, 1'b1);
    @(posedge aclk);
  endtask : axi_rd

  task automatic wr_ok(input logic [11:0] ofs, input logic [31:0] d);
    axi_wr(adr(ofs), d, 4'hF, rsp);
    chk_word({30'h0, rsp}, {30'h0, dscg_pkg::RESP_OKAY});
  endtask : wr_ok

  task automatic rd_exp(input logic [11:0] ofs, input logic [31:0] e);
    axi_rd(adr(ofs), rd, rsp);
    chk_word(rd, e);
    chk_word({30'h0, rsp}, {30'h0, dscg_pkg::RESP_OKAY});
  endtask : rd_exp

  task automatic t_reset;
    rd_exp(12'h060, 32'h00000000);
    rd_exp(12'h100, 32'h00000000);
    rd_exp(12'h110, 32'h00000000);
    rd_exp(12'h128, 32'h00000000);
    rd_exp(12'h200, 32'h00000000);
    rd_exp(12'h204, 32'h00000000);
    chk_unit(9'h000);
    chk_bit(irq, 1'b0);
  endtask : t_reset

  // reserved bits must stay zero, byte lanes select fields
  task automatic t_layout;
    wr_ok(12'h128, 32'hFFFFFFFF);
    rd_exp(12'h128, 32'h5000007F);
    wr_ok(12'h128, 32'h00000000);
    axi_wr(adr(12'h128), 32'hFFFFFFFF, 4'h1, rsp);
    rd_exp(12'h128, 32'h0000007F);
    axi_wr(adr(12'h128), 32'hFFFFFFFF, 4'h8, rsp);
    rd_exp(12'h128, 32'h5000007F);
    wr_ok(12'h128, 32'hAFFFFF80);
    rd_exp(12'h128, 32'h00000000);
  endtask : t_layout

  task automatic t_decode;
    wr_ok(12'h128, 32'h00000041);
    axi_wr(adr(12'h12C), 32'hFFFFFFFF, 4'hF, rsp);
    chk_word({30'h0, rsp}, {30'h0, dscg_pkg::RESP_SLVERR});
    axi_rd(adr(12'h12C), rd, rsp);
    chk_word({30'h0, rsp}, {30'h0, dscg_pkg::RESP_SLVERR});
    chk_word(rd, 32'h00000000);
    axi_wr(32'h400FF128, 32'h00000000, 4'hF, rsp);
    chk_word({30'h0, rsp}, {30'h0, dscg_pkg::RESP_SLVERR});
    rd_exp(12'h128, 32'h00000041);
  endtask : t_decode

  // pins pass a two-flop synchroniser, then the enable register
  task automatic mode_to(input logic s, input logic d, input logic [8:0] e);
    sleep_req <= s;
    deep_sleep_req <= d;
    repeat (5) @(posedge aclk);
    chk_unit(e);
  endtask : mode_to

  task automatic t_modes;
    wr_ok(12'h100, 32'h00000001);
    wr_ok(12'h110, 32'h10000000);
    wr_ok(12'h128, 32'h40000000);
    wr_ok(12'h060, 32'h00000000);
    mode_to(1'b0, 1'b1, 9'h001);
    mode_to(1'b1, 1'b0, 9'h001);
    wr_ok(12'h060, 32'h08000000);
    mode_to(1'b0, 1'b1, 9'h100);
    mode_to(1'b1, 1'b1, 9'h100);
    wr_ok(12'h128, 32'h00000000);
    mode_to(1'b0, 1'b1, 9'h000);
    mode_to(1'b1, 1'b0, 9'h080);
    mode_to(1'b0, 1'b0, 9'h001);
  endtask : t_modes

  task automatic poke(input logic [8:0] u, input logic f);
    unit_access <= u;
    @(posedge aclk);
    unit_access <= 9'h000;
    @(posedge aclk);
    chk_bit(bus_fault, f);
    @(posedge aclk);
    chk_bit(bus_fault, 1'b0);
  endtask : poke

  task automatic t_fault;
    wr_ok(12'h204, 32'h00000002);
    poke(9'h001, 1'b0);
    rd_exp(12'h200, 32'h00000000);
    chk_bit(irq, 1'b0);
    poke(9'h002, 1'b1);
    rd_exp(12'h200, 32'h00000002);
    chk_bit(irq, 1'b1);
    poke(9'h040, 1'b1);
    rd_exp(12'h200, 32'h00000042);
    wr_ok(12'h200, 32'h00000002);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b0);
    rd_exp(12'h200, 32'h00000040);
    wr_ok(12'h204, 32'h00000040);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b1);
    wr_ok(12'h200, 32'h00000040);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b0);
  endtask : t_fault

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_layout();
    t_decode();
    t_modes();
    t_fault();
    close_out();
  end

  // the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    close_out();
  end
endmodule : dscg_top_test
